// ### qcd_pkg.sv
package qcd_pkg;

  // Opcodes decoded in both lane modes, with four-lane command mode set or clear.
  localparam logic [7:0] OP_WREN    = 8'h06;
  localparam logic [7:0] OP_VWREN   = 8'h50;
  localparam logic [7:0] OP_WRDI    = 8'h04;
  localparam logic [7:0] OP_RDID    = 8'hAB;
  localparam logic [7:0] OP_SETRP   = 8'hC0;
  localparam logic [7:0] OP_RDSR1   = 8'h05;
  localparam logic [7:0] OP_RDSR2   = 8'h35;
  localparam logic [7:0] OP_WRSR1   = 8'h01;
  localparam logic [7:0] OP_WRSR2   = 8'h31;
  localparam logic [7:0] OP_PP      = 8'h02;
  localparam logic [7:0] OP_QPP     = 8'h32;
  localparam logic [7:0] OP_SECPROG = 8'h42;
  localparam logic [7:0] OP_SECERAS = 8'h44;
  localparam logic [7:0] OP_SE4     = 8'h20;
  localparam logic [7:0] OP_BE32    = 8'h52;
  localparam logic [7:0] OP_BE64    = 8'hD8;
  localparam logic [7:0] OP_CE_A    = 8'hC7;
  localparam logic [7:0] OP_CE_B    = 8'h60;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME  = 8'h7A;
  localparam logic [7:0] OP_PDOWN   = 8'hB9;
  localparam logic [7:0] OP_RSTEN   = 8'h66;
  localparam logic [7:0] OP_RST     = 8'h99;

  // Byte counts of a frame, opcode included.
  localparam logic [9:0] N_OP    = 10'h001;
  localparam logic [9:0] N_ARG1  = 10'h002;
  localparam logic [9:0] N_ARG2  = 10'h003;
  localparam logic [9:0] N_ADDR  = 10'h004;
  localparam logic [9:0] N_DATA1 = 10'h005;
  localparam logic [9:0] N_MAX   = 10'h3FF;

  // Bits moved per serial clock and bits per byte.
  localparam logic [3:0] STEP_QUAD = 4'h4;
  localparam logic [3:0] STEP_DUAL = 4'h2;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Status layout: busy and latch bits are live, the rest are stored.
  localparam int         SR1_BUSY_BIT = 0;
  localparam int         SR1_WEL_BIT  = 1;
  localparam int         SR2_QE_BIT   = 1;
  localparam logic [7:0] SR1_WMASK    = 8'hFC;
  localparam logic [7:0] SR_RESET     = 8'h00;

  // Read parameter byte and security register selection.
  localparam logic [7:0] RP_RESET     = 8'h00;
  localparam int         RP_DUMMY_LSB = 4;
  localparam logic [7:0] SEC_HI       = 8'h00;
  localparam logic [7:0] SEC_R1       = 8'h10;
  localparam logic [7:0] SEC_R2       = 8'h20;
  localparam logic [7:0] SEC_R3       = 8'h30;

  typedef enum logic [3:0] {
    QCD_K_NONE, QCD_K_PROG, QCD_K_SEC_PROG, QCD_K_ERASE4, QCD_K_ERASE32,
    QCD_K_ERASE64, QCD_K_CHIP, QCD_K_SEC_ERASE, QCD_K_WRSR, QCD_K_SUSPEND,
    QCD_K_RESUME
  } qcd_kind_e;

  // Command handed to the array engine.
  typedef struct packed {
    logic          valid;
    qcd_kind_e     kind;
    logic [23:0]   addr;
    logic [8:0]    len;
    logic [1:0]    sec;
  } qcd_cmd_s;

endpackage

// ### qcd_decoder.sv
`timescale 1ns/10ps
module qcd_decoder #(
  parameter int         PAGE_BYTES = 256,
  parameter logic [7:0] DEVICE_ID  = 8'h5A  // Arbitrary identification value.
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                link_sclk,
  input  wire logic                cs_n,
  input  wire logic [3:0]          lane_i,
  output      logic [3:0]          lane_o,
  output      logic [3:0]          lane_oe,
  input  wire logic                dual_lane_mode,
  input  wire logic                four_lane_command_mode,
  input  wire logic                array_busy,
  input  wire logic                array_done,
  input  wire logic [7:0]          pbuf_rd_idx,
  output      logic [7:0]          pbuf_rd_data,
  output      qcd_pkg::qcd_cmd_s   cmd,
  output      logic                write_enable_latch,
  output      logic [15:0]         status,
  output      logic [3:0]          rd_dummy_clocks,
  output      logic [3:0]          rd_wrap_sel,
  output      logic                powered_down
);

  localparam int IW           = $clog2(PAGE_BYTES);
  localparam int RP_DUMMY_LSB = qcd_pkg::RP_DUMMY_LSB;

  if (PAGE_BYTES < 2 || PAGE_BYTES > 256 || (1 << IW) != PAGE_BYTES) begin : g_chk
    $error("PAGE_BYTES must be a power of two from 2 to 256.");
  end

  // Picks the lanes for one clock of an outgoing byte.
  function automatic logic [3:0] lane_bits(input logic [7:0] b, input logic [2:0] pos,
                                           input logic dual);
    logic [7:0] sh;
    sh = b << pos;
    if (dual) begin
      lane_bits = {2'b00, sh[7:6]};
    end else begin
      lane_bits = sh[7:4];
    end
  endfunction

  // ---------------- Link domain ----------------
  logic [2:0]          bit_q;
  logic [9:0]          bcnt_q;
  logic [7:0]          sh_q;
  logic                dual_s1_q;
  logic                dual_s2_q;
  logic                tog_q;
  logic [9:0]          cnt_rec_q;
  logic                part_rec_q;
  logic [7:0]          op_q;
  logic [23:0]         addr_q;
  logic [IW-1:0]       wptr_q;
  logic [8:0]          dcnt_q;
  logic [7:0]          pbuf_q [PAGE_BYTES];
  logic [7:0]          in_byte;
  logic [3:0]          bit_sum;
  logic                byte_done;
  logic [9:0]          bcnt_d;
  logic                is_prog_op;
  logic [7:0]          out_byte;
  logic                rd_active;
  logic [15:0]         stat_shadow_q;

  // Assembles bytes high part first from the active lanes.
  always_comb begin
    bit_sum    = {1'b0, bit_q} + (dual_s2_q ? qcd_pkg::STEP_DUAL : qcd_pkg::STEP_QUAD);
    byte_done  = (bit_sum == qcd_pkg::BYTE_BITS);
    in_byte    = dual_s2_q ? {sh_q[5:0], lane_i[1:0]} : {sh_q[3:0], lane_i};
    bcnt_d     = (byte_done && bcnt_q != qcd_pkg::N_MAX) ? bcnt_q + 10'h001 : bcnt_q;
    is_prog_op = (op_q == qcd_pkg::OP_PP) || (op_q == qcd_pkg::OP_QPP) ||
                 (op_q == qcd_pkg::OP_SECPROG);
  end

  // Lane mode is a static level; it is synchronised before the shifter uses it.
  always_ff @(posedge link_sclk or posedge rst) begin
    if (rst) begin
      dual_s1_q <= 1'b0;
      dual_s2_q <= 1'b0;
    end else begin
      dual_s1_q <= dual_lane_mode;
      dual_s2_q <= dual_s1_q;
    end
  end

  // Frame position counters restart whenever chip select is high.
  always_ff @(posedge link_sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_q  <= 3'h0;
      bcnt_q <= 10'h000;
    end else begin
      bit_q  <= bit_sum[2:0];
      bcnt_q <= bcnt_d;
    end
  end

  // Frame records survive chip select so the core can read them after the frame.
  always_ff @(posedge link_sclk or posedge rst) begin
    if (rst) begin
      sh_q       <= 8'h00;
      tog_q      <= 1'b0;
      cnt_rec_q  <= 10'h000;
      part_rec_q <= 1'b0;
      op_q       <= 8'h00;
      addr_q     <= 24'h000000;
      wptr_q     <= '0;
      dcnt_q     <= 9'h000;
    end else begin
      sh_q       <= in_byte;
      cnt_rec_q  <= bcnt_d;
      part_rec_q <= !byte_done;
      if (bcnt_q == 10'h000 && bit_q == 3'h0) begin
        tog_q <= ~tog_q;
      end
      if (byte_done) begin
        if (bcnt_q == 10'h000) begin
          op_q <= in_byte;
        end else if (bcnt_q < qcd_pkg::N_ADDR) begin
          addr_q <= {addr_q[15:0], in_byte};
        end
        if (bcnt_q == qcd_pkg::N_ARG2) begin
          wptr_q <= in_byte[IW-1:0];
          dcnt_q <= 9'h000;
        end else if (bcnt_q >= qcd_pkg::N_ADDR && is_prog_op) begin
          wptr_q <= wptr_q + 1'b1;
          if (dcnt_q != 9'(PAGE_BYTES)) begin
            dcnt_q <= dcnt_q + 9'h001;
          end
        end
      end
    end
  end

  // Page buffer; the index wraps inside the page so late bytes overwrite early ones.
  always_ff @(posedge link_sclk) begin
    if (byte_done && bcnt_q >= qcd_pkg::N_ADDR && is_prog_op) begin
      pbuf_q[wptr_q] <= in_byte;
    end
  end

  // Read answers: status repeats, the ID follows three dummy bytes.
  always_comb begin
    out_byte  = DEVICE_ID;
    rd_active = 1'b0;
    if (op_q == qcd_pkg::OP_RDSR1) begin
      out_byte  = stat_shadow_q[7:0];
      rd_active = (bcnt_q >= qcd_pkg::N_OP);
    end else if (op_q == qcd_pkg::OP_RDSR2) begin
      out_byte  = stat_shadow_q[15:8];
      rd_active = (bcnt_q >= qcd_pkg::N_OP);
    end else if (op_q == qcd_pkg::OP_RDID) begin
      rd_active = (bcnt_q >= qcd_pkg::N_ADDR);
    end
  end

  // Output lanes change on the falling edge so the host samples on the rise.
  always_ff @(negedge link_sclk or posedge cs_n) begin
    if (cs_n) begin
      lane_o  <= 4'h0;
      lane_oe <= 4'h0;
    end else begin
      lane_o  <= lane_bits(out_byte, bit_q, dual_s2_q);
      lane_oe <= rd_active ? (dual_s2_q ? 4'h3 : 4'hF) : 4'h0;
    end
  end

  // ---------------- Core domain ----------------
  logic        cs_s1_q;
  logic        cs_s2_q;
  logic        cs_s3_q;
  logic        tog_s1_q;
  logic        tog_s2_q;
  logic        seen_q;
  logic        wel_q;
  logic        vol_arm_q;
  logic        pd_q;
  logic        rst_arm_q;
  logic [7:0]  sr1_q;
  logic [7:0]  sr2_q;
  logic [7:0]  rp_q;
  logic        frame_end;
  logic        exec;
  logic        live;
  logic        wr_ok;
  logic        sec_ok;
  logic        wrsr_req;
  logic        wrsr_vol;
  logic        wrsr_nv;
  logic [7:0]  new_sr1;
  logic [7:0]  new_sr2;
  logic        upd_sr1;
  logic        upd_sr2;
  qcd_pkg::qcd_kind_e kind_d;

  // Chip select and the frame toggle cross as levels through two flip-flops.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_s1_q  <= 1'b1;
      cs_s2_q  <= 1'b1;
      cs_s3_q  <= 1'b1;
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      seen_q   <= 1'b0;
    end else begin
      cs_s1_q  <= cs_n;
      cs_s2_q  <= cs_s1_q;
      cs_s3_q  <= cs_s2_q;
      tog_s1_q <= tog_q;
      tog_s2_q <= tog_s1_q;
      if (frame_end) begin
        seen_q <= tog_s2_q;
      end
    end
  end

  // Decodes the finished frame; link records are stable while chip select is high.
  always_comb begin
    frame_end = cs_s2_q && !cs_s3_q;
    exec      = frame_end && (tog_s2_q != seen_q) && !part_rec_q;
    live      = exec && (!pd_q || op_q == qcd_pkg::OP_RDID);
    wr_ok     = wel_q && !array_busy;
    sec_ok    = (addr_q[23:16] == qcd_pkg::SEC_HI) &&
                ((addr_q[15:8] == qcd_pkg::SEC_R1) || (addr_q[15:8] == qcd_pkg::SEC_R2) ||
                 (addr_q[15:8] == qcd_pkg::SEC_R3));
    wrsr_req  = live && (((op_q == qcd_pkg::OP_WRSR1) &&
                          (cnt_rec_q == qcd_pkg::N_ARG1 || cnt_rec_q == qcd_pkg::N_ARG2)) ||
                         ((op_q == qcd_pkg::OP_WRSR2) && cnt_rec_q == qcd_pkg::N_ARG1));
    wrsr_vol  = wrsr_req && vol_arm_q && !array_busy;
    wrsr_nv   = wrsr_req && !vol_arm_q && wr_ok;
    upd_sr1   = (op_q == qcd_pkg::OP_WRSR1);
    upd_sr2   = (op_q == qcd_pkg::OP_WRSR2) || (cnt_rec_q == qcd_pkg::N_ARG2);
    new_sr1   = (cnt_rec_q == qcd_pkg::N_ARG2) ? addr_q[15:8] : addr_q[7:0];
    new_sr2   = addr_q[7:0];
    if (four_lane_command_mode) begin
      new_sr2[qcd_pkg::SR2_QE_BIT] = sr2_q[qcd_pkg::SR2_QE_BIT];
    end
    kind_d = qcd_pkg::QCD_K_NONE;
    if (live && !pd_q) begin
      if (wrsr_nv) begin
        kind_d = qcd_pkg::QCD_K_WRSR;
      end else if ((op_q == qcd_pkg::OP_PP || op_q == qcd_pkg::OP_QPP) &&
                   cnt_rec_q >= qcd_pkg::N_DATA1 && wr_ok) begin
        kind_d = qcd_pkg::QCD_K_PROG;
      end else if (op_q == qcd_pkg::OP_SECPROG && cnt_rec_q >= qcd_pkg::N_DATA1 &&
                   wr_ok && sec_ok) begin
        kind_d = qcd_pkg::QCD_K_SEC_PROG;
      end else if (cnt_rec_q == qcd_pkg::N_ADDR && wr_ok) begin
        if (op_q == qcd_pkg::OP_SE4) begin
          kind_d = qcd_pkg::QCD_K_ERASE4;
        end else if (op_q == qcd_pkg::OP_BE32) begin
          kind_d = qcd_pkg::QCD_K_ERASE32;
        end else if (op_q == qcd_pkg::OP_BE64) begin
          kind_d = qcd_pkg::QCD_K_ERASE64;
        end else if (op_q == qcd_pkg::OP_SECERAS && sec_ok) begin
          kind_d = qcd_pkg::QCD_K_SEC_ERASE;
        end
      end else if (cnt_rec_q == qcd_pkg::N_OP) begin
        if ((op_q == qcd_pkg::OP_CE_A || op_q == qcd_pkg::OP_CE_B) && wr_ok) begin
          kind_d = qcd_pkg::QCD_K_CHIP;
        end else if (op_q == qcd_pkg::OP_SUSPEND) begin
          kind_d = qcd_pkg::QCD_K_SUSPEND;
        end else if (op_q == qcd_pkg::OP_RESUME) begin
          kind_d = qcd_pkg::QCD_K_RESUME;
        end
      end
    end
  end

  // Write enable latch; a set in the same cycle as a completion wins.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wel_q <= 1'b0;
    end else begin
      if (array_done) begin
        wel_q <= 1'b0;
      end
      if (live && !pd_q && cnt_rec_q == qcd_pkg::N_OP) begin
        if (op_q == qcd_pkg::OP_WRDI || (op_q == qcd_pkg::OP_RST && rst_arm_q)) begin
          wel_q <= 1'b0;
        end else if (op_q == qcd_pkg::OP_WREN) begin
          wel_q <= 1'b1;
        end
      end
    end
  end

  // Volatile arm lasts until the status write uses it or a disable or an armed software reset cancels it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vol_arm_q <= 1'b0;
    end else if (live && !pd_q) begin
      if (cnt_rec_q == qcd_pkg::N_OP && op_q == qcd_pkg::OP_VWREN) begin
        vol_arm_q <= 1'b1;
      end else if (cnt_rec_q == qcd_pkg::N_OP &&
                   (op_q == qcd_pkg::OP_WRDI || (op_q == qcd_pkg::OP_RST && rst_arm_q))) begin
        vol_arm_q <= 1'b0;
      end else if (wrsr_vol) begin
        vol_arm_q <= 1'b0;
      end
    end
  end

  // Stored status bits; the array engine persists them on a non-volatile write.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sr1_q <= qcd_pkg::SR_RESET;
      sr2_q <= qcd_pkg::SR_RESET;
    end else if (wrsr_vol || wrsr_nv) begin
      if (upd_sr1) begin
        sr1_q <= new_sr1 & qcd_pkg::SR1_WMASK;
      end
      if (upd_sr2) begin
        sr2_q <= new_sr2;
      end
    end
  end

  // Read parameters, power-down and the two-step software reset.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rp_q      <= qcd_pkg::RP_RESET;
      pd_q      <= 1'b0;
      rst_arm_q <= 1'b0;
    end else if (live) begin
      rst_arm_q <= (op_q == qcd_pkg::OP_RSTEN) && !pd_q;
      if (op_q == qcd_pkg::OP_RDID) begin
        pd_q <= 1'b0;
      end else if (op_q == qcd_pkg::OP_PDOWN && cnt_rec_q == qcd_pkg::N_OP) begin
        pd_q <= 1'b1;
      end else if (op_q == qcd_pkg::OP_SETRP && cnt_rec_q == qcd_pkg::N_ARG1) begin
        rp_q <= addr_q[7:0];
      end else if (op_q == qcd_pkg::OP_RST && rst_arm_q && cnt_rec_q == qcd_pkg::N_OP) begin
        rp_q <= qcd_pkg::RP_RESET;
      end
    end
  end

  // Registered outputs; the shadow freezes while a frame is open.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd                <= '0;
      write_enable_latch <= 1'b0;
      status             <= 16'h0000;
      stat_shadow_q      <= 16'h0000;
      rd_dummy_clocks    <= 4'h2;
      rd_wrap_sel        <= 4'h0;
      powered_down       <= 1'b0;
      pbuf_rd_data       <= 8'h00;
    end else begin
      cmd.valid          <= (kind_d != qcd_pkg::QCD_K_NONE);
      cmd.kind           <= kind_d;
      cmd.addr           <= addr_q;
      cmd.len            <= dcnt_q;
      cmd.sec            <= addr_q[13:12];
      write_enable_latch <= wel_q;
      status             <= {sr2_q, sr1_q[7:2], wel_q, array_busy};
      if (cs_s2_q) begin
        stat_shadow_q <= {sr2_q, sr1_q[7:2], wel_q, array_busy};
      end
      rd_dummy_clocks    <= {1'b0, rp_q[RP_DUMMY_LSB+1 -: 2], 1'b0} + 4'h2;
      rd_wrap_sel        <= rp_q[3:0];
      powered_down       <= pd_q;
      pbuf_rd_data       <= pbuf_q[pbuf_rd_idx[IW-1:0]];
    end
  end

  // ---------------- Checks ----------------
  property p_wren;
    @(posedge clk) disable iff (rst)
      (exec && !pd_q && op_q == qcd_pkg::OP_WREN && cnt_rec_q == qcd_pkg::N_OP)
      |=> ##1 write_enable_latch;
  endproperty
  a_wren: assert property (p_wren) else $error("Write enable did not set the latch.");

  property p_wrdi;
    @(posedge clk) disable iff (rst)
      (exec && !pd_q && op_q == qcd_pkg::OP_WRDI && cnt_rec_q == qcd_pkg::N_OP)
      |=> !wel_q && !vol_arm_q;
  endproperty
  a_wrdi: assert property (p_wrdi) else $error("Write disable left latch or arm set.");

  property p_vwren;
    @(posedge clk) disable iff (rst)
      (exec && op_q == qcd_pkg::OP_VWREN && !array_done) |=> wel_q == $past(wel_q);
  endproperty
  a_vwren: assert property (p_vwren) else $error("Volatile enable changed the latch.");

  property p_guard;
    @(posedge clk) disable iff (rst)
      (cmd.valid && cmd.kind != qcd_pkg::QCD_K_SUSPEND && cmd.kind != qcd_pkg::QCD_K_RESUME)
      |-> $past(wel_q);
  endproperty
  a_guard: assert property (p_guard) else $error("Write issued without the latch.");

  property p_done;
    @(posedge clk) disable iff (rst)
      (array_done && !(exec && op_q == qcd_pkg::OP_WREN)) ##1 !exec |=> !wel_q;
  endproperty
  a_done: assert property (p_done) else $error("Latch survived operation completion.");

  property p_dummy;
    @(posedge clk) disable iff (rst)
      (exec && !pd_q && op_q == qcd_pkg::OP_SETRP && cnt_rec_q == qcd_pkg::N_ARG1)
      |=> ##1 rd_dummy_clocks == 4'h2 * ({2'b00, $past(addr_q[RP_DUMMY_LSB+1 -: 2], 2)} + 4'h1)
              && rd_dummy_clocks[0] == 1'b0;
  endproperty
  a_dummy: assert property (p_dummy) else $error("Dummy clock count wrong.");

  property p_qe;
    @(posedge clk) disable iff (rst)
      (four_lane_command_mode && (wrsr_vol || wrsr_nv))
      |=> sr2_q[qcd_pkg::SR2_QE_BIT] == $past(sr2_q[qcd_pkg::SR2_QE_BIT]);
  endproperty
  a_qe: assert property (p_qe) else $error("Quad enable changed in four-lane mode.");

  property p_trunc;
    @(posedge clk) disable iff (rst)
      (frame_end && part_rec_q) |=> !cmd.valid && $stable(rp_q) && $stable(sr1_q);
  endproperty
  a_trunc: assert property (p_trunc) else $error("Truncated frame had an effect.");

  property p_sec;
    @(posedge clk) disable iff (rst)
      (cmd.valid && (cmd.kind == qcd_pkg::QCD_K_SEC_PROG || cmd.kind == qcd_pkg::QCD_K_SEC_ERASE))
      |-> cmd.addr[23:16] == 8'h00 && cmd.sec != 2'b00 && cmd.addr[11:8] == 4'h0;
  endproperty
  a_sec: assert property (p_sec) else $error("Security program outside the registers.");

endmodule // qcd_decoder

// ### qcd_host.sv
`timescale 1ns/10ps
// Host controller model; its serial clock runs only inside frames.
module qcd_host (
  output logic        link_sclk,
  output logic        cs_n,
  output logic [3:0]  lane_i,
  input  wire logic [3:0] lane_o,
  input  wire logic [3:0] lane_oe
);
  logic [15:0] rd_q;
  logic [3:0]  oe_q;

  // Idle levels before the first frame.
  initial begin
    link_sclk = 1'b0;
    cs_n = 1'b0;
    lane_i = 4'h0;
    #1 cs_n = 1'b1; // A real rising edge resets the frame counters before the first frame.
  end

  // Sends nib nibbles of v, high nibble first, then samples rd nibbles.
  task automatic frame(input int nib, input logic [63:0] v, input int rd);
    cs_n = 1'b0;
    #400;
    for (int i = nib - 1; i >= 0; i--) begin
      lane_i = v[i*4 +: 4];
      #62.5 link_sclk = 1'b1;
      #62.5 link_sclk = 1'b0;
    end
    lane_i = ~lane_i; // Released lanes must not keep the last nibble.
    for (int i = 0; i < rd; i++) begin
      #62.5 link_sclk = 1'b1;
      rd_q = {rd_q[11:0], lane_o};
      oe_q = lane_oe;
      #62.5 link_sclk = 1'b0;
    end
    #62.5 cs_n = 1'b1;
    #500;
  endtask
endmodule // qcd_host

// ### qcd_decoder_test.sv
`timescale 1ns/10ps
module qcd_decoder_test;
  localparam logic [7:0] ID = 8'h3C; // Arbitrary identification value.
  logic clk = 1'b0;
  logic rst, dual_lane_mode, four_lane_command_mode, array_busy, array_done;
  logic link_sclk, cs_n, write_enable_latch, powered_down;
  logic [3:0] lane_i, lane_o, lane_oe, rd_dummy_clocks, rd_wrap_sel;
  logic [7:0] pbuf_rd_idx, pbuf_rd_data, p, x;
  logic [15:0] status, d;
  logic [23:0] a;
  qcd_pkg::qcd_cmd_s cmd, last_cmd;
  int fail_count = 0;
  int tests_run = 0;
  int cmd_cnt = 0;
  int n0;

  qcd_host u_qcd_host (.link_sclk(link_sclk), .cs_n(cs_n), .lane_i(lane_i), .lane_o(lane_o),
    .lane_oe(lane_oe));
  qcd_decoder #(.DEVICE_ID(ID)) u_qcd_decoder (.clk(clk), .rst(rst),
    .link_sclk(link_sclk), .cs_n(cs_n), .lane_i(lane_i), .lane_o(lane_o), .lane_oe(lane_oe),
    .dual_lane_mode(dual_lane_mode), .four_lane_command_mode(four_lane_command_mode),
    .array_busy(array_busy), .array_done(array_done), .pbuf_rd_idx(pbuf_rd_idx),
    .pbuf_rd_data(pbuf_rd_data), .cmd(cmd), .write_enable_latch(write_enable_latch),
    .status(status), .rd_dummy_clocks(rd_dummy_clocks), .rd_wrap_sel(rd_wrap_sel),
    .powered_down(powered_down));

  // Core clock, 100 ns period.
  always #50 clk = ~clk;

  // Keeps the last command pulse, since it stands for one cycle only.
  always @(posedge clk)
    if (cmd.valid === 1'b1) begin
      last_cmd <= cmd;
      cmd_cnt <= cmd_cnt + 1;
    end

  function automatic logic [3:0] dummies(input logic [7:0] prm);
    return 4'(2 * (prm[5:4] + 1));
  endfunction

  // Two-lane read as the host collects it: one bit pair per nibble, high pair first.
  function automatic logic [15:0] spread2(input logic [7:0] b);
    return {2'b00, b[7:6], 2'b00, b[5:4], 2'b00, b[3:2], 2'b00, b[1:0]};
  endfunction

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // One framed instruction, then time for the result to cross over.
  task automatic op(input int nib, input logic [63:0] v);
    u_qcd_host.frame(nib, v, 0);
    repeat (2) @(negedge clk);
  endtask

  task automatic done_pulse();
    array_done = 1'b1;
    @(negedge clk);
    array_done = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  // Cuts a hang short.
  initial begin
    #500000;
    fail_count++;
    stop_test();
  end

  // Main sequence; core inputs change on the falling edge.
  initial begin
    void'($urandom(98008));
    rst = 1'b0;
    #1;
    rst = 1'b1; // A real edge, so the link side resets before its clock ever runs.
    {dual_lane_mode, array_busy, array_done} = 3'h0;
    four_lane_command_mode = 1'b1;
    pbuf_rd_idx = 8'h00;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check(write_enable_latch, 0);
    check(rd_dummy_clocks, 2);
    op(3, 64'h060);
    check(write_enable_latch, 0);
    op(2, 64'h50);
    check(write_enable_latch, 0);
    a = 24'($urandom);
    d = 16'($urandom);
    n0 = cmd_cnt;
    op(12, {8'h02, a, d});
    check(cmd_cnt - n0, 0);
    op(2, 64'h06);
    check(write_enable_latch, 1);
    u_qcd_host.frame(2, 64'h05, 4);
    check(u_qcd_host.rd_q, 16'h0202);
    check(u_qcd_host.oe_q, 4'hF);
    op(12, {8'h02, a, d});
    check(cmd_cnt - n0, 1);
    check(last_cmd.kind, qcd_pkg::QCD_K_PROG);
    check(last_cmd.addr, a);
    check(last_cmd.len, 2);
    pbuf_rd_idx = a[7:0] + 8'h01;
    repeat (2) @(negedge clk);
    check(pbuf_rd_data, d[7:0]);
    done_pulse();
    check(write_enable_latch, 0);
    x = 8'($urandom);
    op(2, 64'h50);
    op(6, {8'h01, x, 8'hFF});
    check(status, {8'hFD, x[7:2], 2'b00});
    op(2, 64'h50);
    op(2, 64'h04);
    op(6, {8'h01, ~x, 8'h00});
    check(status, {8'hFD, x[7:2], 2'b00});
    four_lane_command_mode = 1'b0;
    op(2, 64'h50);
    op(4, {8'h31, 8'h02});
    check(status[15:8], 8'h02);
    u_qcd_host.frame(2, 64'h35, 2);
    check(u_qcd_host.rd_q[7:0], 8'h02);
    @(negedge clk);
    four_lane_command_mode = 1'b1;
    for (int i = 0; i < 4; i++) begin
      p = 8'($urandom);
      p[5:4] = i[1:0];
      op(4, {8'hC0, p});
      check(rd_dummy_clocks, dummies(p));
      check(rd_wrap_sel, p[3:0]);
    end
    op(2, 64'h66);
    op(2, 64'h99);
    check(rd_dummy_clocks, 2);
    check(rd_wrap_sel, 0);
    for (int r = 1; r < 5; r++) begin
      n0 = cmd_cnt;
      op(2, 64'h06);
      op(8, {8'h44, 8'h00, 4'(r), 12'h000});
      check(cmd_cnt - n0, 24'(r < 4));
      if (r < 4) check(last_cmd.sec, 24'(r));
      done_pulse();
    end
    op(2, 64'h75);
    check(last_cmd.kind, qcd_pkg::QCD_K_SUSPEND);
    op(2, 64'h7A);
    check(last_cmd.kind, qcd_pkg::QCD_K_RESUME);
    array_busy = 1'b1;
    op(2, 64'h06);
    check(status[1:0], 2'b11);
    n0 = cmd_cnt;
    op(12, {8'h02, a, d});
    check(cmd_cnt - n0, 0);
    array_busy = 1'b0;
    op(2, 64'h04);
    check(write_enable_latch, 0);
    op(2, 64'hB9);
    check(powered_down, 1);
    op(2, 64'h06);
    check(write_enable_latch, 0);
    u_qcd_host.frame(8, 64'hAB000000, 2);
    repeat (2) @(negedge clk);
    check(u_qcd_host.rd_q[7:0], ID);
    check(powered_down, 0);
    n0 = cmd_cnt;
    op(10, {8'hEB, a, 8'hF0});
    check(cmd_cnt - n0, 0);
    dual_lane_mode = 1'b1;
    op(2, 64'h00); // Carries the new lane mode over; the link clock runs only in frames.
    op(4, 64'h0012);
    check(write_enable_latch, 1);
    u_qcd_host.frame(4, 64'h0011, 4);
    check(u_qcd_host.rd_q, spread2({x[7:2], 2'b10}));
    check(u_qcd_host.oe_q, 4'h3);
    stop_test();
  end
endmodule // qcd_decoder_test
